// ==== common/interp_fir_cfg.svh ====
// Purpose: Offsets, field positions and counts for the interpolating input filter
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef INTERP_FIR_CFG_SVH
`define INTERP_FIR_CFG_SVH
`define ADR_FLEN 8'h0a
`define ADR_COFS 8'h0b
`define ADR_TAPS 8'h0c
`define ADR_SCDV 8'h0d
`define ADR_FILTER_DATA_MEMORY_LO 8'h20
`define ADR_FILTER_DATA_MEMORY_HI 8'h3f
`define ADR_FILTER_COEFFICIENT_MEMORY_LO 8'h80
`define SCALE_HI 7
`define SCALE_LO 6
`define DIV_HI 4
`define FLEN_HI 6
`define COFS_HI 6
`define TAPS_HI 3
`define CFG_RST 8'h00
`define LAST_BIT_IDX 6'h1f
`define WORD_BITS 6'h20
`define IDX_IDLE 6'h21
`define PROD_SHIFT 5'h0f
`endif

// ==== common/interp_fir_pkg.sv ====
// Purpose: Types shared by the serial input and filter modules
// Assumes: Nothing
// Notes: Output width fixed here so the structs stay packed
package interp_fir_pkg;
   localparam int FIR_OUT_W = 18;
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } iq_sample_t;
   typedef struct packed {
      logic signed [FIR_OUT_W-1:0] i;
      logic signed [FIR_OUT_W-1:0] q;
   } iq_out_t;
   typedef struct packed {
      logic [4:0] divider;
      logic [23:0] interp;
   } frame_cfg_t;
   typedef enum logic [1:0] {S_IDLE, S_MAC, S_OUT} mac_state_t;
endpackage

// ==== logic/bit_clock_framer.sv ====
// Purpose: Bit clock divider and frame pulse generator
// Assumes: Divider held static while the channel runs
// Notes: Frame edges coincide with bit clock rising edges, except where sleep or channel reset drops the frame
`timescale 1ns/10ps
`include "interp_fir_cfg.svh"
module bit_clock_framer (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Channel control
   input wire logic chan_reset_i,
   input wire logic sleep_i,
   input wire interp_fir_pkg::frame_cfg_t cfg_i,
   // Serial timing
   output logic bit_clk_o,
   output logic frame_o,
   output logic bit_rise_o,
   output logic frame_start_o
);
   import interp_fir_pkg::*;
   logic [4:0] div_cnt_q, div_cnt_d;
   logic bclk_q, bclk_d;
   logic [23:0] smp_cnt_q, smp_cnt_d, reload;
   logic pend_q, pend_d;
   logic frame_q, frame_d;
   logic toggle, rise, tick, start;
   logic [4:0] hold_q;
   logic seen_q;

   // ************************************
   // Divider and frame next state
   // ************************************
   always_comb begin
      toggle = (div_cnt_q == 5'h00);
      rise = toggle && !bclk_q;
      tick = (smp_cnt_q == 24'h000000);
      start = rise && pend_q && !sleep_i;
      reload = (cfg_i.interp == 24'h000000) ? 24'h000000 : cfg_i.interp - 24'h000001;
      div_cnt_d = toggle ? cfg_i.divider : div_cnt_q - 5'h01;
      bclk_d = toggle ? !bclk_q : bclk_q;
      // One tick per channel interp count of master clocks
      smp_cnt_d = tick ? reload : smp_cnt_q - 24'h000001;
      // Tick waits for next bit clock edge, stretching or shortening a frame
      pend_d = (pend_q && !start && !sleep_i) || tick;
      frame_d = frame_q;
      if (sleep_i) begin
         frame_d = 1'b0;
      end else if (rise) begin
         frame_d = start;
      end
      if (chan_reset_i) begin
         div_cnt_d = 5'h00;
         bclk_d = 1'b0;
         smp_cnt_d = reload;
         pend_d = 1'b0;
         frame_d = 1'b0;
      end
   end

   // Registers
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         div_cnt_q <= 5'h00;
         bclk_q <= 1'b0;
         smp_cnt_q <= 24'h000000;
         pend_q <= 1'b0;
         frame_q <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_d;
         bclk_q <= bclk_d;
         smp_cnt_q <= smp_cnt_d;
         pend_q <= pend_d;
         frame_q <= frame_d;
      end
   end

   assign bit_clk_o = bclk_q;
   assign frame_o = frame_q;
   assign bit_rise_o = rise && !chan_reset_i;
   assign frame_start_o = start && !chan_reset_i;

   // Helper: cycles since last toggle, for half period check
   always_ff @(posedge clock_i) begin
      if (rst_i || chan_reset_i) begin
         hold_q <= 5'h00;
         seen_q <= 1'b0;
      end else begin
         hold_q <= toggle ? 5'h00 : hold_q + 5'h01;
         seen_q <= seen_q || toggle;
      end
   end

   property p_clk_low_reset;
      @(posedge clock_i) disable iff (rst_i) chan_reset_i |=> !bclk_q;
   endproperty
   a_clk_low_reset: assert property (p_clk_low_reset) else $error("bit clock not low in reset");

   property p_clk_start;
      @(posedge clock_i) disable iff (rst_i) $fell(chan_reset_i) |=> bclk_q;
   endproperty
   a_clk_start: assert property (p_clk_start) else $error("bit clock late after release");

   property p_half_period;
      @(posedge clock_i) disable iff (rst_i)
         toggle && seen_q && !chan_reset_i && $stable(cfg_i.divider)
         |-> hold_q == cfg_i.divider;
   endproperty
   a_half_period: assert property (p_half_period) else $error("bit clock half period wrong");

   property p_frame_on_edge;
      @(posedge clock_i) disable iff (rst_i)
         $changed(frame_q) && !$past(sleep_i) && !$past(chan_reset_i) |-> $past(rise);
   endproperty
   a_frame_on_edge: assert property (p_frame_on_edge) else $error("frame moved off bit edge");

   property p_sleep_low;
      @(posedge clock_i) disable iff (rst_i) sleep_i |=> !frame_q;
   endproperty
   a_sleep_low: assert property (p_sleep_low) else $error("frame high in sleep");

   property p_first_withheld;
      @(posedge clock_i) disable iff (rst_i) $fell(chan_reset_i) |-> !frame_q [*3];
   endproperty
   a_first_withheld: assert property (p_first_withheld) else $error("frame too soon");
endmodule // bit_clock_framer

// ==== logic/serial_input_interp_fir.sv ====
// Purpose: Channel serial input port and polyphase interpolating filter
// Assumes: Downstream stage pulses next_req_i once per filter output
// Notes: Data memory is never cleared by reset
`timescale 1ns/10ps
`include "interp_fir_cfg.svh"

module serial_input_interp_fir #(
   parameter int ACC_W = 40
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Channel control
   input wire logic chan_reset_i,
   input wire logic sleep_i,
   input wire logic [23:0] channel_interp_i,
   input wire logic [6:0] filter_interp_m1_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // Serial port
   input wire logic serial_sample_in_i,
   output logic bit_clk_o,
   output logic frame_pulse_out_o,
   // Filter output
   input wire logic next_req_i,
   output logic filt_valid_o,
   output interp_fir_pkg::iq_out_t filt_out_o
);
   import interp_fir_pkg::*;

   // ************************************
   // Declarations
   // ************************************
   logic [6:0] flen_q, flen_d;
   logic [6:0] cofs_q, cofs_d;
   logic [3:0] taps_q, taps_d;
   logic [7:0] scdv_q, scdv_d;
   logic [15:0] rdata_q, rdata_d;
   logic signed [15:0] filter_coefficient_memory_q [128];
   logic signed [15:0] filter_data_memory_i_q [16];
   logic signed [15:0] filter_data_memory_q_q [16];
   logic filter_coefficient_memory_we, filter_data_memory_we;
   logic [6:0] filter_coefficient_memory_wa;
   logic [3:0] filter_data_memory_wa;
   logic [15:0] filter_data_memory_wi, filter_data_memory_wq;
   logic filter_data_memory_wi_en, filter_data_memory_wq_en;
   mac_state_t state_q, state_d;
   logic [6:0] phase_q, phase_d;
   logic [3:0] tap_q, tap_d;
   logic [3:0] wptr_q, wptr_d;
   logic signed [ACC_W-1:0] acc_i_q, acc_i_d, acc_q_q, acc_q_d;
   iq_out_t out_q, out_d;
   logic valid_q, valid_d;
   logic push;
   logic [4:0] tap_cnt;
   logic [11:0] c_base;
   logic [6:0] c_idx;
   logic [3:0] d_idx;
   logic signed [31:0] prod_i, prod_q;
   logic [4:0] shamt;
   logic signed [ACC_W-1:0] sh_i, sh_q;
   frame_cfg_t fcfg;
   iq_sample_t word;
   logic bit_rise, frame_start, bclk, frame;
   logic bclk_q, frame_q;
   logic [4:0] mac_cyc_q;

   // ************************************
   // Serial port
   // ************************************
   // Both timing pins are outputs; the port only listens on data
   assign fcfg.divider = scdv_q[`DIV_HI:0];
   assign fcfg.interp = channel_interp_i;

   bit_clock_framer u_framer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .chan_reset_i(chan_reset_i),
      .sleep_i(sleep_i),
      .cfg_i(fcfg),
      .bit_clk_o(bclk),
      .frame_o(frame),
      .bit_rise_o(bit_rise),
      .frame_start_o(frame_start)
   );

   serial_word_capture u_capture (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .chan_reset_i(chan_reset_i),
      .bit_rise_i(bit_rise),
      .frame_start_i(frame_start),
      .serial_sample_in_i(serial_sample_in_i),
      .word_o(word),
      .word_valid_o()
   );

   // Pins copy framer flops; one cycle late but still glitch free
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         bclk_q <= 1'b0;
         frame_q <= 1'b0;
      end else begin
         bclk_q <= bclk;
         frame_q <= frame;
      end
   end

   // ************************************
   // Configuration registers
   // ************************************
   // Reserved bits are dropped on write and read back as zero
   always_comb begin
      flen_d = flen_q;
      cofs_d = cofs_q;
      taps_d = taps_q;
      scdv_d = scdv_q;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `ADR_FLEN: flen_d = reg_wdata_i[`FLEN_HI:0];
            `ADR_COFS: cofs_d = reg_wdata_i[`COFS_HI:0];
            `ADR_TAPS: taps_d = reg_wdata_i[`TAPS_HI:0];
            `ADR_SCDV: scdv_d = {reg_wdata_i[`SCALE_HI:`SCALE_LO], 1'b0,
               reg_wdata_i[`DIV_HI:0]};
            default: ;
         endcase
      end
   end

   // Read data, registered one cycle after the strobe
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_i) begin
         rdata_d = 16'h0000;
         if (reg_addr_i == `ADR_FLEN) begin
            rdata_d = {9'h000, flen_q};
         end else if (reg_addr_i == `ADR_COFS) begin
            rdata_d = {9'h000, cofs_q};
         end else if (reg_addr_i == `ADR_TAPS) begin
            rdata_d = {12'h000, taps_q};
         end else if (reg_addr_i == `ADR_SCDV) begin
            rdata_d = {8'h00, scdv_q};
         end else if (reg_addr_i >= `ADR_FILTER_COEFFICIENT_MEMORY_LO) begin
            rdata_d = filter_coefficient_memory_q[reg_addr_i[6:0]];
         end else if (reg_addr_i >= `ADR_FILTER_DATA_MEMORY_LO && reg_addr_i <= `ADR_FILTER_DATA_MEMORY_HI) begin
            rdata_d = reg_addr_i[0] ? filter_data_memory_q_q[reg_addr_i[4:1]] : filter_data_memory_i_q[reg_addr_i[4:1]];
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         flen_q <= 7'(`CFG_RST);
         cofs_q <= 7'h00;
         taps_q <= 4'h0;
         scdv_q <= `CFG_RST;
         rdata_q <= 16'h0000;
      end else begin
         flen_q <= flen_d;
         cofs_q <= cofs_d;
         taps_q <= taps_d;
         scdv_q <= scdv_d;
         rdata_q <= rdata_d;
      end
   end

   // ************************************
   // Coefficient and data memories
   // ************************************
   // Sample push beats a data memory register write in the same cycle
   always_comb begin
      filter_coefficient_memory_we = reg_wr_i && (reg_addr_i >= `ADR_FILTER_COEFFICIENT_MEMORY_LO);
      filter_coefficient_memory_wa = reg_addr_i[6:0];
      filter_data_memory_we = reg_wr_i && reg_addr_i >= `ADR_FILTER_DATA_MEMORY_LO && reg_addr_i <= `ADR_FILTER_DATA_MEMORY_HI;
      filter_data_memory_wa = reg_addr_i[4:1];
      filter_data_memory_wi = reg_wdata_i;
      filter_data_memory_wq = reg_wdata_i;
      filter_data_memory_wi_en = filter_data_memory_we && !reg_addr_i[0];
      filter_data_memory_wq_en = filter_data_memory_we && reg_addr_i[0];
      if (push) begin
         filter_data_memory_wa = wptr_q + 4'h1;
         filter_data_memory_wi = word.i;
         filter_data_memory_wq = word.q;
         filter_data_memory_wi_en = 1'b1;
         filter_data_memory_wq_en = 1'b1;
      end
   end

   // No reset: contents persist, software clears them
   always_ff @(posedge clock_i) begin
      if (filter_coefficient_memory_we) begin
         filter_coefficient_memory_q[filter_coefficient_memory_wa] <= reg_wdata_i;
      end
      if (filter_data_memory_wi_en) begin
         filter_data_memory_i_q[filter_data_memory_wa] <= filter_data_memory_wi;
      end
      if (filter_data_memory_wq_en) begin
         filter_data_memory_q_q[filter_data_memory_wa] <= filter_data_memory_wq;
      end
   end

   // ************************************
   // Polyphase multiply-accumulate
   // ************************************
   // One tap per clock, I and Q in parallel; zero inputs are not skipped
   always_comb begin
      tap_cnt = {1'b0, taps_q} + 5'h01;
      c_base = 12'(phase_q) * 12'(tap_cnt);
      c_idx = cofs_q + c_base[6:0] + {3'h0, tap_q};
      d_idx = wptr_q - tap_q;
      prod_i = filter_coefficient_memory_q[c_idx] * filter_data_memory_i_q[d_idx];
      prod_q = filter_coefficient_memory_q[c_idx] * filter_data_memory_q_q[d_idx];
      shamt = `PROD_SHIFT + {3'h0, scdv_q[`SCALE_HI:`SCALE_LO]};
      sh_i = acc_i_q >>> shamt;
      sh_q = acc_q_q >>> shamt;
   end

   // Sequencer: new sample enters only at phase zero
   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      tap_d = tap_q;
      wptr_d = wptr_q;
      acc_i_d = acc_i_q;
      acc_q_d = acc_q_q;
      out_d = out_q;
      valid_d = 1'b0;
      push = 1'b0;
      unique case (state_q)
         S_IDLE: begin
            if (next_req_i) begin
               push = (phase_q == 7'h00);
               wptr_d = push ? wptr_q + 4'h1 : wptr_q;
               acc_i_d = '0;
               acc_q_d = '0;
               tap_d = 4'h0;
               state_d = S_MAC;
            end
         end
         S_MAC: begin
            acc_i_d = acc_i_q + ACC_W'(prod_i);
            acc_q_d = acc_q_q + ACC_W'(prod_q);
            tap_d = tap_q + 4'h1;
            if (tap_q == taps_q) begin
               state_d = S_OUT;
            end
         end
         S_OUT: begin
            out_d.i = sh_i[FIR_OUT_W-1:0];
            out_d.q = sh_q[FIR_OUT_W-1:0];
            valid_d = 1'b1;
            phase_d = (phase_q >= filter_interp_m1_i) ? 7'h00 : phase_q + 7'h01;
            state_d = S_IDLE;
         end
      endcase
      if (chan_reset_i) begin
         state_d = S_IDLE;
         phase_d = 7'h00;
         valid_d = 1'b0;
         push = 1'b0;
         wptr_d = wptr_q;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         phase_q <= 7'h00;
         tap_q <= 4'h0;
         wptr_q <= 4'h0;
         acc_i_q <= '0;
         acc_q_q <= '0;
         out_q <= '0;
         valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         tap_q <= tap_d;
         wptr_q <= wptr_d;
         acc_i_q <= acc_i_d;
         acc_q_q <= acc_q_d;
         out_q <= out_d;
         valid_q <= valid_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign bit_clk_o = bclk_q;
   assign frame_pulse_out_o = frame_q;
   assign filt_valid_o = valid_q;
   assign filt_out_o = out_q;

   // Helper: cycles spent accumulating
   always_ff @(posedge clock_i) begin
      if (rst_i || state_q == S_IDLE) begin
         mac_cyc_q <= 5'h00;
      end else if (state_q == S_MAC) begin
         mac_cyc_q <= mac_cyc_q + 5'h01;
      end
   end

   property p_mac_len;
      @(posedge clock_i) disable iff (rst_i)
         state_q == S_OUT && $stable(taps_q) |-> mac_cyc_q == tap_cnt;
   endproperty
   a_mac_len: assert property (p_mac_len) else $error("wrong tap count per output");

   property p_push;
      @(posedge clock_i) disable iff (rst_i)
         state_q == S_IDLE && next_req_i && phase_q == 7'h00 && !chan_reset_i
         |=> wptr_q == $past(wptr_q) + 4'h1 ##1 !filt_valid_o;
   endproperty
   a_push: assert property (p_push) else $error("sample not pushed at phase zero");

   property p_reserved;
      @(posedge clock_i) disable iff (rst_i)
         reg_rd_i && reg_addr_i == `ADR_SCDV |=> reg_rdata_o[5] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit reads one");
endmodule // serial_input_interp_fir

// ==== logic/serial_word_capture.sv ====
// Purpose: Shifts in one 32-bit I/Q word per frame
// Assumes: Data input synchronous to the master clock
// Notes: First bit is taken on the bit clock edge after the frame edge
`timescale 1ns/10ps
`include "interp_fir_cfg.svh"
module serial_word_capture (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic chan_reset_i,
   // Serial timing and data
   input wire logic bit_rise_i,
   input wire logic frame_start_i,
   input wire logic serial_sample_in_i,
   // Assembled word
   output interp_fir_pkg::iq_sample_t word_o,
   output logic word_valid_o
);
   import interp_fir_pkg::*;
   logic [5:0] idx_q, idx_d;
   logic [31:0] shreg_q, shreg_d;
   iq_sample_t word_q, word_d;
   logic valid_q, valid_d;
   logic take;

   // ************************************
   // Shift and count
   // ************************************
   always_comb begin
      take = bit_rise_i && (idx_q < `WORD_BITS);
      shreg_d = take ? {shreg_q[30:0], serial_sample_in_i} : shreg_q;
      valid_d = take && (idx_q == `LAST_BIT_IDX);
      word_d = valid_d ? {shreg_q[30:0], serial_sample_in_i} : word_q;
      idx_d = idx_q;
      if (frame_start_i) begin
         idx_d = 6'h00;
      end else if (bit_rise_i && idx_q < `IDX_IDLE) begin
         idx_d = idx_q + 6'h01;
      end
      if (chan_reset_i) begin
         idx_d = `IDX_IDLE;
         valid_d = 1'b0;
      end
   end

   // Registers
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         idx_q <= `IDX_IDLE;
         shreg_q <= 32'h00000000;
         word_q <= '0;
         valid_q <= 1'b0;
      end else begin
         idx_q <= idx_d;
         shreg_q <= shreg_d;
         word_q <= word_d;
         valid_q <= valid_d;
      end
   end

   assign word_o = word_q;
   assign word_valid_o = valid_q;

   property p_word_at_last;
      @(posedge clock_i) disable iff (rst_i)
         word_valid_o |-> $past(bit_rise_i) && $past(idx_q) == `LAST_BIT_IDX;
   endproperty
   a_word_at_last: assert property (p_word_at_last) else $error("word not on 32nd bit");
endmodule // serial_word_capture

// ==== tb/dsp_port_model.sv ====
// Purpose: Far-side serial port model feeding one word per frame
// Assumes: Word is set before the frame that carries it
// Notes: Line keeps toggling once the word has gone out
`timescale 1ns/10ps
module dsp_port_model (
   // Serial port
   input wire logic bit_clk_i,
   input wire logic frame_i,
   output logic sdata_o,
   // Word to send
   input wire logic [31:0] word_i
);
   logic [31:0] sh_q;
   int idx;
   initial begin
      sdata_o = 1'b0;
      idx = -1;
   end
   // Change just after each clock rise, so the bit stands a full period
   always @(posedge bit_clk_i) begin
      #1;
      if (frame_i === 1'b1) begin
         sh_q = word_i;
         idx = 31;
      end else begin
         idx = idx - 1;
      end
      if (idx >= 0) begin
         sdata_o = sh_q[idx];
      end else begin
         sdata_o = ~sdata_o;
      end
   end
endmodule // dsp_port_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the serial input and interpolating filter
// Assumes: Divider and tap count static while the channel runs
// Notes: Filter results compared against an integer model
`timescale 1ns/10ps
module testbench;
   import interp_fir_pkg::*;
   logic clock_i, rst_i, chan_reset_i, sleep_i, reg_wr_i, reg_rd_i, sdata, next_req_i, sel;
   logic [23:0] chan_l;
   logic [6:0] fim1;
   logic [7:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o;
   logic bit_clk_o, frame_pulse_out_o, filt_valid_o;
   iq_out_t filt_out_o;
   logic [31:0] word;
   logic [31:0] hist[$];
   longint coef[4];
   int miscompares, comparisons;
   wire watched = sel ? frame_pulse_out_o : bit_clk_o;

   serial_input_interp_fir i_dut (.clock_i(clock_i), .rst_i(rst_i),
      .chan_reset_i(chan_reset_i), .sleep_i(sleep_i), .channel_interp_i(chan_l),
      .filter_interp_m1_i(fim1), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .serial_sample_in_i(sdata), .bit_clk_o(bit_clk_o), .frame_pulse_out_o(frame_pulse_out_o),
      .next_req_i(next_req_i), .filt_valid_o(filt_valid_o), .filt_out_o(filt_out_o));
   dsp_port_model i_dsp (.bit_clk_i(bit_clk_o), .frame_i(frame_pulse_out_o), .sdata_o(sdata),
      .word_i(word));

   // **********
   // Helpers
   // **********
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Strobe dropped a cycle early so back-to-back calls never re-drive at one instant
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      tick();
      reg_wr_i = 1'b0;
      tick();
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      tick();
      reg_rd_i = 1'b0;
      d = reg_rdata_o;
      tick();
   endtask
   // Cycles until the watched pin next rises, bounded
   task automatic wait_rise(input int lim, output int n);
      n = 0;
      while (watched !== 1'b0 && n < lim) begin tick(); n++; end
      while (watched !== 1'b1 && n < lim) begin tick(); n++; end
   endtask

   // Reset values, masks of reserved bits, unmapped address
   task automatic test_regs;
      logic [7:0] a[5] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h05};
      logic [15:0] m[5] = '{16'h7f, 16'h7f, 16'h0f, 16'hdf, 16'h0};
      logic [15:0] d, v;
      for (int i = 0; i < 5; i++) begin
         rd(a[i], v);
         check(36'(v), 36'h0);
         d = 16'($urandom());
         wr(a[i], d);
         rd(a[i], v);
         check(36'(v), 36'(d & m[i]));
      end
      $display("test_regs done");
   endtask

   task automatic test_bclk;
      int divs[3] = '{0, 1, 31};
      int n;
      sel = 1'b0;
      for (int i = 0; i < 3; i++) begin
         chan_reset_i = 1'b1;
         wr(8'h0d, 16'(divs[i]));
         repeat (4) begin tick(); check(36'(bit_clk_o), 36'h0); end
         chan_reset_i = 1'b0;
         wait_rise(10, n);
         check(36'(n inside {[1:3]}), 36'h1);
         wait_rise(200, n);
         check(36'(n), 36'(2 * (divs[i] + 1)));
      end
      $display("test_bclk done");
   endtask

   // Divider 2 gives 6-cycle bits, not a divisor of 400
   task automatic test_frames;
      int n, w, tot;
      sel = 1'b1;
      chan_reset_i = 1'b1;
      wr(8'h0d, 16'h2);
      chan_reset_i = 1'b0;
      wait_rise(2000, n);
      check(36'(n >= 400), 36'h1);
      tot = 0;
      for (int i = 0; i < 8; i++) begin
         w = 0;
         while (frame_pulse_out_o === 1'b1 && w < 100) begin tick(); w++; end
         check(36'(w), 36'd6);
         wait_rise(1000, n);
         check(36'((w + n) inside {396, 402}), 36'h1);
         tot += w + n;
      end
      check(36'(tot inside {[3194:3206]}), 36'h1);
      sleep_i = 1'b1;
      tick(10);
      n = 0;
      repeat (900) begin tick(); n += int'(frame_pulse_out_o === 1'b1); end
      check(36'(n), 36'h0);
      sleep_i = 1'b0;
      $display("test_frames done");
   endtask

   // Two phases of two taps, offset wrapping past the top of memory
   task automatic test_filter;
      logic [35:0] e;
      longint ai, aq;
      int n, g;
      sel = 1'b1;
      chan_reset_i = 1'b1;
      wr(8'h0d, 16'h0);
      wr(8'h0c, 16'h1);
      wr(8'h0a, 16'h3);
      wr(8'h0b, 16'h7e);
      for (int i = 0; i < 4; i++) begin
         coef[i] = longint'($signed(16'($urandom())));
         wr(8'h80 + ((8'h7e + 8'(i)) & 8'h7f), 16'(coef[i]));
      end
      for (int a = 32; a < 64; a++) wr(8'(a), 16'h0);
      hist = '{32'h0, 32'h0};
      chan_reset_i = 1'b0;
      for (int f = 0; f < 8; f++) begin
         g = f % 4;
         word = $urandom();
         wr(8'h0d, 16'(g << 6));
         wait_rise(2000, n);
         tick(80);
         hist.push_front(word);
         for (int p = 0; p < 2; p++) begin
            ai = 0;
            aq = 0;
            for (int k = 0; k < 2; k++) begin
               ai += coef[p * 2 + k] * longint'($signed(hist[k][31:16]));
               aq += coef[p * 2 + k] * longint'($signed(hist[k][15:0]));
            end
            e = {18'(ai >>> (15 + g)), 18'(aq >>> (15 + g))};
            next_req_i = 1'b1;
            tick();
            next_req_i = 1'b0;
            n = 0;
            while (filt_valid_o !== 1'b1 && n < 50) begin tick(); n++; end
            // Two taps per phase: two accumulate cycles, then the output cycle
            check(36'(n), 36'd3);
            check(filt_out_o, e);
            tick();
            check(36'(filt_valid_o), 36'h0);
         end
      end
      $display("test_filter done");
   endtask

   task automatic report_and_stop;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Watchdog, nearly four times the expected run
   initial begin
      #3000000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      rst_i = 1'b1;
      chan_reset_i = 1'b1;
      {sleep_i, reg_wr_i, reg_rd_i, next_req_i, sel} = 5'h0;
      reg_addr_i = 8'h0;
      reg_wdata_i = 16'h0;
      chan_l = 24'd400;
      fim1 = 7'd1;
      word = 32'h0;
      miscompares = 0;
      comparisons = 0;
      void'($urandom(32'h1e0b78d0));
      tick(5);
      rst_i = 1'b0;
      test_regs();
      test_bclk();
      test_frames();
      test_filter();
      report_and_stop();
   end
endmodule // testbench
